/* File: core/ras_return_stack.sv */
// return address stack with pc, vectors and register port
// Notes on behaviour
// RULE1: program counter is 21 bits wide
// RULE2: fetch beyond implemented memory returns zeros
// RULE3: implemented memory 32K large, 16K small
// RULE4: reset vector zero, interrupt vectors 8h, 18h
// RULE5: interrupt wake-up with enable loads vector
// RULE6: interrupt wake-up with enable pushes pc
// RULE7: up to 31 nested calls or interrupts
// RULE8: push on call, relative call, interrupt
// RULE9: pop on return, literal return, interrupt return
// RULE10: calls and returns leave pc latches alone
// RULE11: 31 words of 21 bits, 5-bit pointer
// RULE12: reset sets pointer zero, no word there
// RULE13: push increments pointer then writes word
// RULE14: pop reads word then decrements pointer
// RULE15: software reads and writes pointer and top
// RULE16: status bits report full stack levels
// RULE17: three top registers show selected word
// RULE18: software masks interrupts while editing top
// RULE19: stack storage outside program and data space
// RULE20: separate program and data buses
// RULE21: full flag after 31 pushes, sticky
// RULE22: overflow reset pushes pc+2 and resets
// RULE23: no overflow reset: pointer holds at 31
// RULE24: empty pop loads zero, sets underflow flag
// RULE25: top register write updates selected byte
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "ras_defs.svh"
module ras_return_stack
  import ras_pkg::*;
#(
  parameter bit LARGE_MEM = 1'b1
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic                      por,
  input  wire logic [2:0]                stackOp,
  input  wire logic                      pcAdvance,
  input  wire logic                      pcLoad,
  input  wire logic [`RAS_PC_W-1:0]      pcLoadValue,
  input  wire logic                      highIrq,
  input  wire logic                      low_priority_global_irq_enable,
  input  wire logic                      high_priority_global_irq_enable,
  input  wire logic                      overflow_reset_config_bit,
  input  wire logic [`RAS_PC_W-1:0]      fetchData16Addr,
  input  wire logic [15:0]               progRomData,
  input  wire logic [`RAS_ADDR_W-1:0]    regAddr,
  input  wire logic [`RAS_DATA_W-1:0]    regWdata,
  input  wire logic                      regWrite,
  input  wire logic                      regRead,
  output logic      [`RAS_DATA_W-1:0]    regRdata,
  output logic      [`RAS_PC_W-1:0]      progCounter,
  output logic      [`RAS_PC_W-1:0]      progMemAddr,
  output logic      [15:0]               fetchWord,
  output logic                           stackReset,
  output logic      [`RAS_DATA_W-1:0]    pc_upper_latch,
  output logic      [`RAS_DATA_W-1:0]    pc_high_latch
);

  // storage separate from program and data space [RULE19]
  logic [`RAS_PC_W-1:0] stackMem [1:`RAS_DEPTH];
  logic [`RAS_SP_W-1:0] return_stack_pointer;
  logic                 stack_full_flag;
  logic                 stack_underflow_flag;
  logic [`RAS_PC_W-1:0] memLimit;
  logic [`RAS_PC_W-1:0] topWord;
  logic [`RAS_PC_W-1:0] pushValue;
  logic                 anyEnable;
  logic                 doPush;
  logic                 doPop;
  logic                 swPtrWrite;
  logic                 swTopWrite;
  logic                 lastPush;
  logic [`RAS_PC_W-1:0] next_pc;

  assign anyEnable = low_priority_global_irq_enable | high_priority_global_irq_enable;
  // push sources [RULE8] [RULE6]
  assign doPush = (stackOp == RAS_OP_CALL) || (stackOp == RAS_OP_IRQ) ||
                  ((stackOp == RAS_OP_WAKE) && anyEnable);
  assign doPop = (stackOp == RAS_OP_RET); // [RULE9]
  assign swPtrWrite = regWrite && (regAddr == `RAS_REG_SPTR);
  assign swTopWrite = regWrite && (regAddr <= `RAS_REG_TOPL) && (return_stack_pointer != 5'h00);
  assign lastPush = (return_stack_pointer == 5'(`RAS_DEPTH - 1));
  // implemented memory size per variant [RULE3]
  assign memLimit = LARGE_MEM ? `RAS_MEM_LARGE : `RAS_MEM_SMALL;
  assign topWord = (return_stack_pointer == 5'h00) ? `RAS_RESET_VEC : stackMem[return_stack_pointer]; // [RULE17]
  // overflow reset stores pc plus two [RULE22]
  assign pushValue = (lastPush && overflow_reset_config_bit) ? progCounter + `RAS_PC_STEP : progCounter;

  // program counter, 21 bits [RULE1]
  always_comb begin
    next_pc = progCounter;
    if (pcAdvance) begin
      next_pc = progCounter + `RAS_PC_STEP;
    end
    if (pcLoad) begin
      next_pc = pcLoadValue;
    end
    if (doPop) begin
      // empty pop returns zero [RULE24] [RULE14]
      next_pc = topWord;
    end
    if (stackOp == RAS_OP_IRQ || (stackOp == RAS_OP_WAKE && anyEnable)) begin
      next_pc = highIrq ? `RAS_HIGH_VEC : `RAS_LOW_VEC; // [RULE4] [RULE5]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || stackReset) begin
      progCounter <= `RAS_RESET_VEC; // [RULE4]
    end else begin
      progCounter <= next_pc;
    end
  end

  // pc latches change only by register write or reset [RULE10]
  always_ff @(posedge ref_clk) begin
    if (rst || stackReset) begin
      pc_upper_latch <= 8'h00;
      pc_high_latch  <= 8'h00;
    end else if (regWrite && regAddr == `RAS_REG_PCU) begin
      pc_upper_latch <= {3'h0, regWdata[4:0]};
    end else if (regWrite && regAddr == `RAS_REG_PCH) begin
      pc_high_latch <= regWdata;
    end
  end

  // pointer: increment before write, decrement after read [RULE12] [RULE13] [RULE14] [RULE7]
  always_ff @(posedge ref_clk) begin
    if (rst || stackReset) begin
      return_stack_pointer <= 5'h00;
    end else if (swPtrWrite) begin
      return_stack_pointer <= regWdata[4:0]; // [RULE15]
    end else if (doPush) begin
      if (return_stack_pointer != 5'(`RAS_DEPTH)) begin
        return_stack_pointer <= return_stack_pointer + 5'h01; // [RULE23]
      end
    end else if (doPop && return_stack_pointer != 5'h00) begin
      return_stack_pointer <= return_stack_pointer - 5'h01;
    end
  end

  // 31 words of storage, one per nonzero pointer value [RULE11]
  genvar gi;
  generate
    for (gi = 1; gi <= `RAS_DEPTH; gi = gi + 1) begin : gWord
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          stackMem[gi] <= `RAS_RESET_VEC;
        end else if (doPush && !swPtrWrite && return_stack_pointer == 5'(gi - 1)) begin
          stackMem[gi] <= pushValue; // [RULE13] [RULE23]
        end else if (swTopWrite && return_stack_pointer == 5'(gi)) begin
          // byte update, pointer untouched [RULE25]
          case (regAddr)
            `RAS_REG_TOPU: stackMem[gi][20:16] <= regWdata[4:0];
            `RAS_REG_TOPH: stackMem[gi][15:8]  <= regWdata;
            `RAS_REG_TOPL: stackMem[gi][7:0]   <= regWdata;
            default:       stackMem[gi]        <= stackMem[gi];
          endcase
        end
      end
    end
  endgenerate

  // sticky status, set wins over clear [RULE16] [RULE21] [RULE24]
  always_ff @(posedge ref_clk) begin
    if (por) begin
      stack_full_flag      <= 1'b0;
      stack_underflow_flag <= 1'b0;
    end else begin
      if (doPush && return_stack_pointer >= 5'(`RAS_DEPTH - 1)) begin
        stack_full_flag <= 1'b1;
      end else if (swPtrWrite) begin
        stack_full_flag <= regWdata[`RAS_FULL_BIT];
      end
      if (doPop && return_stack_pointer == 5'h00) begin
        stack_underflow_flag <= 1'b1;
      end else if (swPtrWrite) begin
        stack_underflow_flag <= regWdata[`RAS_UNF_BIT];
      end
    end
  end

  // overflow reset request, one cycle [RULE22]
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stackReset <= 1'b0;
    end else begin
      stackReset <= doPush && !swPtrWrite && lastPush && overflow_reset_config_bit;
    end
  end

  // fetch path on its own bus, zeros past memory [RULE2] [RULE20]
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      progMemAddr <= `RAS_RESET_VEC;
      fetchWord   <= 16'h0000;
    end else begin
      progMemAddr <= progCounter;
      fetchWord   <= (fetchData16Addr < memLimit) ? progRomData : 16'h0000;
    end
  end

  // register read, data one cycle later [RULE15] [RULE17]
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `RAS_REG_TOPU: regRdata <= {3'h0, topWord[20:16]};
        `RAS_REG_TOPH: regRdata <= topWord[15:8];
        `RAS_REG_TOPL: regRdata <= topWord[7:0];
        `RAS_REG_SPTR: regRdata <= {stack_full_flag, stack_underflow_flag, 1'b0, return_stack_pointer};
        `RAS_REG_PCU:  regRdata <= pc_upper_latch;
        `RAS_REG_PCH:  regRdata <= pc_high_latch;
        default:       regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

endmodule

/* File: core/ras_defs.svh */
// constants for the return address stack
`ifndef RAS_DEFS_SVH
`define RAS_DEFS_SVH
`define RAS_PC_W        21
`define RAS_SP_W        5
`define RAS_DEPTH       31
`define RAS_ADDR_W      4
`define RAS_DATA_W      8
`define RAS_RESET_VEC   21'h00_0000
`define RAS_HIGH_VEC    21'h00_0008
`define RAS_LOW_VEC     21'h00_0018
`define RAS_PC_STEP     21'h00_0002
`define RAS_MEM_LARGE   21'h00_8000
`define RAS_MEM_SMALL   21'h00_4000
`define RAS_REG_TOPU    4'h0
`define RAS_REG_TOPH    4'h1
`define RAS_REG_TOPL    4'h2
`define RAS_REG_SPTR    4'h3
`define RAS_REG_PCU     4'h4
`define RAS_REG_PCH     4'h5
`define RAS_FULL_BIT    7
`define RAS_UNF_BIT     6
`endif

/* File: core/ras_pkg.sv */
// types for the return address stack
package ras_pkg;
  typedef enum logic [2:0] {
    RAS_OP_NONE = 3'h0,
    RAS_OP_CALL = 3'h1,
    RAS_OP_RET  = 3'h3,
    RAS_OP_IRQ  = 3'h2,
    RAS_OP_WAKE = 3'h6
  } ras_op_t;
endpackage

/* File: verification/ras_rom_model.sv */
// program memory model answering fetches
`timescale 1ns/100ps
module ras_rom_model (
  input  wire logic [20:0] fetchData16Addr,
  output logic      [15:0] progRomData
);
  assign progRomData = fetchData16Addr[15:0] ^ 16'hc3a5;
endmodule

/* File: verification/ras_return_stack_props.sv */
// port assertions for the return address stack
`timescale 1ns/100ps
module ras_return_stack_props #(
  parameter bit LARGE_MEM = 1'b1
) (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        por,
  input wire logic [2:0]  stackOp,
  input wire logic        pcAdvance,
  input wire logic        pcLoad,
  input wire logic [20:0] pcLoadValue,
  input wire logic        highIrq,
  input wire logic        low_priority_global_irq_enable,
  input wire logic        high_priority_global_irq_enable,
  input wire logic        regRead,
  input wire logic [20:0] fetchData16Addr,
  input wire logic [7:0]  regRdata,
  input wire logic [20:0] progCounter,
  input wire logic [15:0] fetchWord,
  input wire logic        stackReset
);
  localparam logic [20:0] LIMIT = LARGE_MEM ? 21'h00_8000 : 21'h00_4000;
  logic en;
  assign en = low_priority_global_irq_enable | high_priority_global_irq_enable;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst || por);
  sequence vecTake; stackOp == 3'h2 || (stackOp == 3'h6 && en); endsequence
  sequence idleOp; stackOp == 3'h0 && !stackReset; endsequence
  rdata_idle_a: assert property (!regRead |=> regRdata == 8'h00) else $error("read data not idle");
  vec_high_a: assert property (vecTake ##0 highIrq |=> progCounter == 21'h00_0008) else $error("bad vector");
  vec_low_a: assert property (vecTake ##0 !highIrq |=> progCounter == 21'h00_0018) else $error("bad vector");
  wake_gate_a: assert property (stackOp == 3'h6 && !en && !pcLoad && !pcAdvance |=> $stable(progCounter))
    else $error("wake moved pc");
  pc_load_a: assert property (idleOp ##0 pcLoad |=> progCounter == $past(pcLoadValue)) else $error("bad load");
  pc_step_a: assert property (idleOp ##0 pcAdvance && !pcLoad |=> progCounter == $past(progCounter) + 21'h00_0002)
    else $error("bad advance");
  fetch_zero_a: assert property (fetchData16Addr >= LIMIT |=> fetchWord == 16'h0000) else $error("bad fetch");
  ovf_reset_a: assert property (stackReset |-> ##[0:1] progCounter == 21'h00_0000) else $error("pc kept");
endmodule
bind ras_return_stack ras_return_stack_props #(.LARGE_MEM(LARGE_MEM)) props_u (.ref_clk, .rst, .por, .stackOp,
  .pcAdvance, .pcLoad, .pcLoadValue, .highIrq, .low_priority_global_irq_enable, .high_priority_global_irq_enable,
  .regRead, .fetchData16Addr, .regRdata, .progCounter, .fetchWord, .stackReset);

/* File: verification/ras_return_stack_tb.sv */
// bench for the return address stack
`timescale 1ns/100ps
module ras_return_stack_tb;
  logic ref_clk = 0, rst = 1, por = 1, pcAdvance = 0, pcLoad = 0, highIrq = 0, regWrite = 0, regRead = 0;
  logic low_priority_global_irq_enable = 0, high_priority_global_irq_enable = 0, overflow_reset_config_bit = 0;
  logic stackReset, full = 0, unf = 0;
  logic [2:0] stackOp = 0;
  logic [3:0] regAddr = 0;
  logic [7:0] regWdata = 0, regRdata, pc_upper_latch, pc_high_latch;
  logic [15:0] progRomData, fetchWord;
  logic [20:0] pcLoadValue = 0, fetchData16Addr = 0, progCounter, progMemAddr, pc = 0, stk [32];
  int n_mismatch = 0, tests_run = 0, sp = 0, seed = 32'h0000_8e33;
  ras_rom_model rom_u (.fetchData16Addr, .progRomData);
  ras_return_stack dut_u (.ref_clk, .rst, .por, .stackOp, .pcAdvance, .pcLoad, .pcLoadValue, .highIrq,
    .low_priority_global_irq_enable, .high_priority_global_irq_enable, .overflow_reset_config_bit, .fetchData16Addr,
    .progRomData, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .progCounter, .progMemAddr, .fetchWord,
    .stackReset, .pc_upper_latch, .pc_high_latch);
  initial forever #25 ref_clk = ~ref_clk;
  task automatic chk(logic [20:0] seen, logic [20:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic op(logic [2:0] o, logic ld, logic adv);
    logic [20:0] t;
    logic v;
    t = 21'($random(seed));
    v = o == 3'h2 || (o == 3'h6 && (low_priority_global_irq_enable || high_priority_global_irq_enable));
    @(posedge ref_clk);
    stackOp <= o;
    pcLoad <= ld;
    pcAdvance <= adv;
    pcLoadValue <= t;
    full |= (o == 3'h1 || v) && sp >= 30;
    if ((o == 3'h1 || v) && sp < 31) begin
      sp++;
      stk[sp] = pc + ((overflow_reset_config_bit && sp == 31) ? 21'h00_0002 : 21'h00_0000);
    end
    unf |= o == 3'h3 && sp == 0;
    if (adv) pc = pc + 21'h00_0002;
    if (ld) pc = t;
    if (o == 3'h3) pc = sp ? stk[sp] : 21'h00_0000;
    if (o == 3'h3 && sp > 0) sp--;
    if (v) pc = highIrq ? 21'h00_0008 : 21'h00_0018;
    @(posedge ref_clk);
    stackOp <= 3'h0;
    pcLoad <= 1'b0;
    pcAdvance <= 1'b0;
    @(negedge ref_clk);
    if (!(overflow_reset_config_bit && sp == 31)) chk(progCounter, pc);
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    @(negedge ref_clk);
    chk(21'(regRdata), 21'(e));
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    if (a == 4'h2 && sp > 0) stk[sp][7:0] = d;
    if (a == 4'h3) {full, unf, sp} = {d[7:6], 27'h000_0000, d[4:0]};
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_mismatch++;
    give_verdict;
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    por <= 1'b0;
    rd(4'h3, 8'h00);
    wr(4'h4, 8'h15);
    wr(4'h5, 8'ha6);
    for (int i = 0; i < 32; i++) op(3'h1, i[0], i[1]);
    rd(4'h3, {full, unf, 1'b0, 5'(sp)});
    rd(4'h0, {3'h0, stk[sp][20:16]});
    rd(4'h1, stk[sp][15:8]);
    wr(4'h2, 8'($random(seed))); // both irq enables still low here
    rd(4'h2, stk[sp][7:0]);
    for (int i = 0; i < 33; i++) op(3'h3, 1'b0, 1'b0);
    rd(4'h3, {full, unf, 1'b0, 5'(sp)});
    chk({5'h00, pc_upper_latch, pc_high_latch}, 21'h00_15a6);
    wr(4'h3, 8'h00);
    rd(4'h3, 8'h00);
    rd(4'hf, 8'h00);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      highIrq <= i[0];
      low_priority_global_irq_enable <= i[1];
      high_priority_global_irq_enable <= i[1] & i[0];
      op(3'h0, i[1], 1'b1);
      op(3'h2, 1'b1, 1'b0);
      op(3'h6, i[0], 1'b0);
    end
    rd(4'h3, {full, unf, 1'b0, 5'(sp)});
    overflow_reset_config_bit <= 1'b1;
    wr(4'h3, 8'h00);
    for (int i = 0; i < 31; i++) op(3'h1, 1'b0, 1'b0);
    repeat (3) @(posedge ref_clk);
    sp = 0;
    pc = 21'h00_0000;
    @(negedge ref_clk);
    chk(progCounter, pc);
    rd(4'h3, 8'h80);
    wr(4'h3, 8'h9f);
    rd(4'h2, stk[31][7:0]);
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      fetchData16Addr <= 21'($random(seed)) >> (i[0] ? 0 : 5);
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk(21'(fetchWord), fetchData16Addr < 21'h00_8000 ? 21'(fetchData16Addr[15:0] ^ 16'hc3a5) : 21'h0);
    end
    chk(progMemAddr, pc);
    give_verdict;
  end
endmodule
